// *** shift_capture_pkg.sv ***
package shift_capture_pkg;

  // Register offsets on the plain port
  localparam logic [3:0] ctrl_offset        = 4'h0;
  localparam logic [3:0] write_reg_offset   = 4'h1;
  localparam logic [3:0] read_reg_offset    = 4'h2;
  localparam logic [3:0] in_data_offset     = 4'h3;
  localparam logic [3:0] out_data_offset    = 4'h4;
  localparam logic [3:0] queue_state_offset = 4'h5;
  localparam logic [3:0] irq_status_offset  = 4'h6;
  localparam logic [3:0] irq_enable_offset  = 4'h7;
  localparam logic [3:0] irq_clear_offset   = 4'h8;

  // Control register fields
  localparam int unsigned ctrl_enable_bit = 0;
  localparam logic [7:0]  ctrl_reset_val  = 8'h00;

  // Interrupt bit positions
  localparam int unsigned irq_load_bit  = 0;
  localparam int unsigned irq_store_bit = 1;
  localparam int unsigned irq_reset_bit = 2;
  localparam logic [2:0]  irq_reset_val = 3'h0;

  // Queue selector values
  localparam logic [1:0] input_queue_id  = 2'h0;
  localparam logic [1:0] output_queue_id = 2'h1;

  // Queue fill state codes
  typedef enum logic [1:0] {
    queue_state_full    = 2'b00,
    queue_state_partial = 2'b01,
    queue_state_empty   = 2'b10,
    queue_state_absent  = 2'b11
  } queue_state_t;

  // Field positions in the queue state register
  localparam int unsigned state_in_lsb  = 0;
  localparam int unsigned state_out_lsb = 2;

  // Enable start-up latency in component clocks
  localparam int unsigned enable_latency_cycles = 1;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic shift_in;
    logic load;
    logic store;
    logic clear;
  } serial_in_t;

endpackage

// *** shift_capture.sv ***
`timescale 1ns/1ps
module shift_capture #(
  parameter int unsigned register_length_bits    = 8,
  parameter bit          input_queue_present     = 1'b1,
  parameter int unsigned input_queue_depth_words = 4,
  parameter int unsigned output_queue_depth_words = 4,
  parameter bit          shift_direction_select  = 1'b0
) (
  // Clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    rstn_i,
  input  wire logic                    clk_en_i,
  // Register port
  input  wire shift_capture_pkg::reg_req_t   req_i,
  output logic [31:0]                  rdata_o,
  // Serial side
  input  wire shift_capture_pkg::serial_in_t ser_i,
  output logic                         shift_out_o,
  // Interrupt
  output logic                         irq_o
);

  localparam int unsigned W  = register_length_bits;
  localparam int unsigned ID = input_queue_depth_words;
  localparam int unsigned OD = output_queue_depth_words;
  localparam int unsigned IA = (ID > 1) ? $clog2(ID) : 1;
  localparam int unsigned OA = (OD > 1) ? $clog2(OD) : 1;

  function automatic shift_capture_pkg::queue_state_t fill_state(
    input int unsigned count,
    input int unsigned depth
  );
    if (count == 0)
      return shift_capture_pkg::queue_state_empty;
    else if (count >= depth)
      return shift_capture_pkg::queue_state_full;
    else
      return shift_capture_pkg::queue_state_partial;
  endfunction

  function automatic logic [W-1:0] pad_word(input logic [31:0] v);
    return v[W-1:0];
  endfunction

  logic [W-1:0]  shreg_q;
  logic          enable_q;
  logic          running_q;
  logic          store_prev_q;
  logic [2:0]    irq_status_q;
  logic [2:0]    irq_enable_q;
  logic [2:0]    irq_clear;
  logic [31:0]   rdata_q;

  // Output queue storage
  logic [W-1:0]  oq_mem [OD];
  logic [OA-1:0] oq_wp_q;
  logic [OA-1:0] oq_rp_q;
  logic [OA:0]   oq_cnt_q;

  // Input queue storage
  logic [W-1:0]  iq_mem [ID];
  logic [IA-1:0] iq_wp_q;
  logic [IA-1:0] iq_rp_q;
  logic [IA:0]   iq_cnt_q;

  logic wr_ctrl;
  logic wr_reg;
  logic wr_in;
  logic rd_out;
  logic store_edge;
  logic do_store;
  logic do_load;
  logic do_clear;
  logic iq_push;
  logic oq_pop;
  shift_capture_pkg::queue_state_t iq_state;
  shift_capture_pkg::queue_state_t oq_state;

  assign wr_ctrl = req_i.wr && req_i.addr == shift_capture_pkg::ctrl_offset;
  assign wr_reg  = req_i.wr && req_i.addr == shift_capture_pkg::write_reg_offset;
  assign wr_in   = req_i.wr && req_i.addr == shift_capture_pkg::in_data_offset;
  assign rd_out  = req_i.rd && req_i.addr == shift_capture_pkg::out_data_offset;
  assign irq_clear = (req_i.wr && req_i.addr == shift_capture_pkg::irq_clear_offset)
                     ? req_i.wdata[2:0] : 3'h0;

  assign store_edge = ser_i.store && !store_prev_q;
  assign do_store   = running_q && store_edge && oq_cnt_q < (OA+1)'(OD);
  assign do_clear   = running_q && ser_i.clear;
  assign do_load    = running_q && ser_i.load && !ser_i.clear
                      && iq_cnt_q != '0;
  assign iq_push    = clk_en_i && wr_in && iq_cnt_q < (IA+1)'(ID);
  assign oq_pop     = clk_en_i && rd_out && oq_cnt_q != '0;

  assign iq_state = input_queue_present ? fill_state(int'(iq_cnt_q), ID)
                                        : shift_capture_pkg::queue_state_absent;
  assign oq_state = fill_state(int'(oq_cnt_q), OD);

  // Enable and one-clock start-up
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      enable_q  <= shift_capture_pkg::ctrl_reset_val[shift_capture_pkg::ctrl_enable_bit];
      running_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (wr_ctrl)
        enable_q <= req_i.wdata[shift_capture_pkg::ctrl_enable_bit];
      running_q <= enable_q;
    end
  end

  // Shift register
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      shreg_q <= '0;
    else if (clk_en_i)
    begin
      if (do_clear)
        shreg_q <= '0;
      else if (do_load)
        shreg_q <= iq_mem[iq_rp_q];
      else if (wr_reg && !running_q)
        shreg_q <= pad_word(req_i.wdata);
      else if (running_q)
      begin
        if (shift_direction_select)
          shreg_q <= {ser_i.shift_in, shreg_q[W-1:1]};
        else
          shreg_q <= {shreg_q[W-2:0], ser_i.shift_in};
      end
    end
  end

  assign shift_out_o = shift_direction_select ? shreg_q[0] : shreg_q[W-1];

  // Store edge detector
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      store_prev_q <= 1'b0;
    else if (clk_en_i)
      store_prev_q <= ser_i.store;
  end

  // Input queue
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      iq_wp_q  <= '0;
      iq_rp_q  <= '0;
      iq_cnt_q <= '0;
    end
    else if (clk_en_i && input_queue_present)
    begin
      if (iq_push)
      begin
        iq_mem[iq_wp_q] <= pad_word(req_i.wdata);
        iq_wp_q <= (iq_wp_q == IA'(ID-1)) ? '0 : iq_wp_q + 1'b1;
      end
      if (do_load)
        iq_rp_q <= (iq_rp_q == IA'(ID-1)) ? '0 : iq_rp_q + 1'b1;
      iq_cnt_q <= iq_cnt_q + (IA+1)'(iq_push) - (IA+1)'(do_load);
    end
  end

  // Output queue
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      oq_wp_q  <= '0;
      oq_rp_q  <= '0;
      oq_cnt_q <= '0;
    end
    else if (clk_en_i)
    begin
      if (do_store)
      begin
        oq_mem[oq_wp_q] <= shreg_q;
        oq_wp_q <= (oq_wp_q == OA'(OD-1)) ? '0 : oq_wp_q + 1'b1;
      end
      if (oq_pop)
        oq_rp_q <= (oq_rp_q == OA'(OD-1)) ? '0 : oq_rp_q + 1'b1;
      oq_cnt_q <= oq_cnt_q + (OA+1)'(do_store) - (OA+1)'(oq_pop);
    end
  end

  // Interrupt status, set wins over clear
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_status_q <= shift_capture_pkg::irq_reset_val;
      irq_enable_q <= shift_capture_pkg::irq_reset_val;
    end
    else if (clk_en_i)
    begin
      if (req_i.wr && req_i.addr == shift_capture_pkg::irq_enable_offset)
        irq_enable_q <= req_i.wdata[2:0];
      irq_status_q <= (irq_status_q & ~irq_clear) | {do_clear, do_store, do_load};
    end
  end

  assign irq_o = |(irq_status_q & irq_enable_q);

  // Read data, one cycle after the strobe
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_q <= 32'h0;
    else if (clk_en_i)
    begin
      rdata_q <= 32'h0;
      if (req_i.rd)
      begin
        unique case (req_i.addr)
          shift_capture_pkg::ctrl_offset:
            rdata_q <= {31'h0, enable_q};
          shift_capture_pkg::read_reg_offset:
            rdata_q <= 32'(shreg_q);
          shift_capture_pkg::out_data_offset:
            rdata_q <= (oq_cnt_q != '0) ? 32'(oq_mem[oq_rp_q]) : 32'h0;
          shift_capture_pkg::queue_state_offset:
            rdata_q <= {28'h0, oq_state, iq_state};
          shift_capture_pkg::irq_status_offset:
            rdata_q <= {29'h0, irq_status_q};
          shift_capture_pkg::irq_enable_offset:
            rdata_q <= {29'h0, irq_enable_q};
          default:
            rdata_q <= 32'h0;
        endcase
      end
    end
  end

  assign rdata_o = rdata_q;

  a_store_push: assert property (@(posedge clock_i) disable iff (!rstn_i)
    clk_en_i && do_store && !oq_pop |=> oq_cnt_q == $past(oq_cnt_q) + 1'b1)
    else $error("store edge did not push a word");

  a_full_ignore: assert property (@(posedge clock_i) disable iff (!rstn_i)
    clk_en_i && oq_state == shift_capture_pkg::queue_state_full && store_edge && !oq_pop
    |=> oq_cnt_q == $past(oq_cnt_q))
    else $error("store accepted while output queue full");

  a_clear_wins: assert property (@(posedge clock_i) disable iff (!rstn_i)
    clk_en_i && running_q && ser_i.clear && ser_i.load |=> shreg_q == '0)
    else $error("clear did not win over load");

  a_load_word: assert property (@(posedge clock_i) disable iff (!rstn_i)
    clk_en_i && do_load |=> shreg_q == $past(iq_mem[iq_rp_q]))
    else $error("load did not move queue word");

  a_start_delay: assert property (@(posedge clock_i) disable iff (!rstn_i)
    clk_en_i && $rose(enable_q) |-> !running_q)
    else $error("operation started without one clock delay");

  a_absent_state: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !input_queue_present |-> iq_state == shift_capture_pkg::queue_state_absent)
    else $error("absent input queue not reported");

  a_empty_state: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (oq_cnt_q == '0) == (oq_state == shift_capture_pkg::queue_state_empty))
    else $error("output queue state mismatch");

  a_shift_out: assert property (@(posedge clock_i) disable iff (!rstn_i)
    clk_en_i && running_q && !do_clear && !do_load && !wr_reg
    |=> shift_out_o == (shift_direction_select ? $past(shreg_q[1]) : $past(shreg_q[W-2])))
    else $error("serial output bit wrong after shift");

  a_read_oldest: assert property (@(posedge clock_i) disable iff (!rstn_i)
    oq_pop |=> rdata_q == 32'($past(oq_mem[oq_rp_q])))
    else $error("output queue read not oldest word");

  a_full_state: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (oq_cnt_q == (OA+1)'(OD)) == (oq_state == shift_capture_pkg::queue_state_full))
    else $error("output queue full state mismatch");

  a_freeze_state: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !clk_en_i |=> $stable(shreg_q) && $stable(oq_cnt_q) && $stable(iq_cnt_q) && $stable(enable_q))
    else $error("state moved while clock enable low");

endmodule

// *** serial_source.sv ***
`timescale 1ns/1ps
module serial_source (
  // Clock
  input  wire logic                     clock_i,
  // Bench knowledge of the input queue
  input  wire logic                     have_word_i,
  // Serial side
  output shift_capture_pkg::serial_in_t ser_o
);

  initial ser_o = '0;

  // Levels change just after the edge and hold until the next strobe call
  task automatic strobe(input logic ld, input logic st, input logic clr, input logic bit_v);
    @(posedge clock_i);
    ser_o.load     <= ld & have_word_i;
    ser_o.store    <= st;
    ser_o.clear    <= clr;
    ser_o.shift_in <= bit_v;
  endtask

endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;

  logic                          clock_i;
  logic                          rstn_i;
  logic                          clk_en_i;
  shift_capture_pkg::reg_req_t   req_i;
  shift_capture_pkg::serial_in_t ser;
  logic [31:0]                   rdata_o;
  logic [31:0]                   bare_rdata;
  logic                          shift_out_o;
  logic                          irq_o;
  logic                          rd_pend_q;
  logic [31:0]                   exp_q[$];
  logic [31:0]                   rng;
  logic [7:0]                    w[6];
  int                            in_cnt;
  int                            bad_count;
  int                            total_checks;
  int                            cycles;

  shift_capture dut_u (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .clk_en_i    (clk_en_i),
    .req_i       (req_i),
    .rdata_o     (rdata_o),
    .ser_i       (ser),
    .shift_out_o (shift_out_o),
    .irq_o       (irq_o)
  );

  // Same block built without the input queue, shifting right
  shift_capture #(
    .input_queue_present    (1'b0),
    .shift_direction_select (1'b1)
  ) bare_u (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .clk_en_i    (clk_en_i),
    .req_i       (req_i),
    .rdata_o     (bare_rdata),
    .ser_i       (ser),
    .shift_out_o (),
    .irq_o       ()
  );

  serial_source ser_u (
    .clock_i     (clock_i),
    .have_word_i (in_cnt != 0),
    .ser_o       (ser)
  );

  always #25 clock_i = ~clock_i;

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req_i <= '{wr: wr, rd: rd, addr: a, wdata: d};
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'h1, 1'h0, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'h0, 1'h1, a, 32'h0);
  endtask

  task automatic idle;
    bus(1'h0, 1'h0, 4'h0, 32'h0);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clock_i)
  begin
    if (rd_pend_q)
      check(rdata_o, exp_q.pop_front());
    rd_pend_q <= req_i.rd;
  end

  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      bad_count++;
      final_report;
    end
  end

  initial
  begin
    clock_i = 1'h0;
    rstn_i = 1'h0;
    clk_en_i = 1'h1;
    req_i = '0;
    rd_pend_q = 1'h0;
    rng = 32'h35;
    in_cnt = 0;
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'h1;
    rd(shift_capture_pkg::ctrl_offset, 32'h0);
    rd(shift_capture_pkg::irq_status_offset, 32'h0);
    rd(4'hf, 32'h0);
    rd(shift_capture_pkg::queue_state_offset, 32'ha);
    idle;
    #1 check(bare_rdata, 32'hb);
    wr(shift_capture_pkg::write_reg_offset, 32'h1a5);
    idle;
    rd(shift_capture_pkg::read_reg_offset, 32'ha5);
    wr(shift_capture_pkg::ctrl_offset, 32'h1);
    for (int i = 0; i < 6; i++)
    begin
      rng = xorshift(rng);
      w[i] = rng[7:0];
    end
    wr(shift_capture_pkg::in_data_offset, {24'h0, w[0]});
    rd(shift_capture_pkg::queue_state_offset, 32'h9);
    for (int i = 1; i < 5; i++)
      wr(shift_capture_pkg::in_data_offset, {24'h0, w[i]});
    rd(shift_capture_pkg::queue_state_offset, 32'h8);
    idle;
    in_cnt = 4;
    for (int k = 0; k < 4; k++)
    begin
      ser_u.strobe(1'h1, 1'h0, 1'h0, 1'h0);
      ser_u.strobe(1'h0, 1'h1, 1'h0, 1'h0);
      #1 check({31'h0, shift_out_o}, {31'h0, w[k][7]});
      in_cnt--;
      ser_u.strobe(1'h0, 1'h0, 1'h0, 1'h0);
    end
    // Queue full: this store edge must be dropped
    ser_u.strobe(1'h1, 1'h1, 1'h0, 1'h1);
    ser_u.strobe(1'h0, 1'h0, 1'h0, 1'h0);
    rd(shift_capture_pkg::queue_state_offset, 32'h2);
    for (int k = 0; k < 4; k++)
      rd(shift_capture_pkg::out_data_offset, {24'h0, w[k]});
    rd(shift_capture_pkg::out_data_offset, 32'h0);
    wr(shift_capture_pkg::in_data_offset, {24'h0, w[5]});
    idle;
    in_cnt = 1;
    ser_u.strobe(1'h1, 1'h0, 1'h0, 1'h1);
    in_cnt = 0;
    ser_u.strobe(1'h0, 1'h0, 1'h0, 1'h1);
    ser_u.strobe(1'h0, 1'h1, 1'h0, 1'h1);
    ser_u.strobe(1'h0, 1'h0, 1'h0, 1'h0);
    rd(shift_capture_pkg::out_data_offset, {24'h0, w[5][6:0], 1'h1});
    wr(shift_capture_pkg::in_data_offset, {24'h0, w[4]});
    #1 check(bare_rdata, 32'hc0);
    idle;
    in_cnt = 1;
    ser_u.strobe(1'h1, 1'h0, 1'h1, 1'h1);
    ser_u.strobe(1'h0, 1'h1, 1'h0, 1'h0);
    ser_u.strobe(1'h0, 1'h0, 1'h0, 1'h0);
    rd(shift_capture_pkg::queue_state_offset, 32'h5);
    rd(shift_capture_pkg::out_data_offset, 32'h0);
    rd(shift_capture_pkg::irq_status_offset, 32'h7);
    wr(shift_capture_pkg::irq_enable_offset, 32'h2);
    idle;
    #1 check({31'h0, irq_o}, 32'h1);
    wr(shift_capture_pkg::irq_enable_offset, 32'h0);
    idle;
    #1 check({31'h0, irq_o}, 32'h0);
    wr(shift_capture_pkg::irq_enable_offset, 32'h7);
    wr(shift_capture_pkg::irq_clear_offset, 32'h7);
    rd(shift_capture_pkg::irq_status_offset, 32'h0);
    idle;
    #1 check({31'h0, irq_o}, 32'h0);
    // Write while frozen must be lost
    @(posedge clock_i);
    clk_en_i <= 1'h0;
    wr(shift_capture_pkg::irq_enable_offset, 32'h5);
    idle;
    clk_en_i <= 1'h1;
    rd(shift_capture_pkg::irq_enable_offset, 32'h7);
    idle;
    repeat (3) @(posedge clock_i);
    final_report;
  end

endmodule
